// ===== cosc_pkg.sv
package cosc_pkg;
    // timing at 25 MHz
    localparam int unsigned CLK_FREQ_HZ        = 25000000;
    localparam int unsigned OE_DELAY_US        = 10;
    localparam int unsigned OE_DELAY_CYC       = OE_DELAY_US * (CLK_FREQ_HZ / 1000000);
    localparam int unsigned STABLE_MS          = 3;
    localparam int unsigned STABLE_CYC         = STABLE_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned SPREAD_MS          = 3;
    localparam int unsigned SPREAD_CYC         = SPREAD_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned CPU_RESUME_MIN     = 2;
    localparam int unsigned CPU_RESUME_MAX     = 6;

    // apb register offsets
    localparam logic [7:0] CPU_CTRL_OFS        = 8'h00;
    localparam logic [7:0] IO_CTRL_OFS         = 8'h04;
    localparam logic [7:0] DISP_CTRL_OFS       = 8'h08;
    localparam logic [7:0] LINK_CTRL_OFS       = 8'h0c;
    localparam logic [7:0] STATUS_OFS          = 8'h10;

    // per-output control field positions (cpu uses 4 bits per output)
    localparam int unsigned F_OE               = 0;
    localparam int unsigned F_PD_TRI           = 1;
    localparam int unsigned F_HALT_TRI         = 2;
    localparam int unsigned F_FREE             = 3;
    localparam int unsigned F_WIDTH            = 4;
    localparam int unsigned LINK_SPREAD_LSB    = 1;
    localparam int unsigned LINK_SPREAD_W      = 4;

    localparam logic [11:0] CPU_CTRL_RST       = 12'h111;
    localparam logic [3:0]  IO_CTRL_RST        = 4'h1;
    localparam logic [1:0]  DISP_CTRL_RST      = 2'h1;
    localparam logic [4:0]  LINK_CTRL_RST      = 5'h01;

    // output drive modes
    typedef enum logic [1:0] {
        COSC_RUN   = 2'b00,
        COSC_IREF6 = 2'b01,
        COSC_IREF2 = 2'b10,
        COSC_TRI   = 2'b11
    } cosc_mode_t;
endpackage

// ===== cosc_delay.sv
`timescale 1ns/1ns
`default_nettype none
// registered drive mode follower: applies a new mode within the oe delay
module cosc_delay (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire cosc_pkg::cosc_mode_t want,
    output cosc_pkg::cosc_mode_t    mode
);
    typedef struct packed {
        cosc_pkg::cosc_mode_t mode;
    } cosc_dly_t;

    cosc_dly_t st_reg;
    cosc_dly_t st_next;

    // a mode change takes one clock boundary, well inside 10 us
    always_comb begin
        st_next      = st_reg;
        st_next.mode = want;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= '{mode: cosc_pkg::COSC_TRI};
        end else begin
            st_reg <= st_next;
        end
    end

    assign mode = st_reg.mode;
endmodule // cosc_delay
`default_nettype wire

// ===== cosc_ctrl.sv
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cosc_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_down_pin,
    input  wire logic        cpu_halt_n,
    input  wire logic        pci_halt_n,
    input  wire logic        free_pci_clock,
    input  wire logic        link_power_down_pin,
    output logic      [5:0]  cpu_mode,
    output logic      [1:0]  io_reference_clock_mode,
    output logic      [1:0]  display_96mhz_clock_mode,
    output logic             link_oe_n,
    output logic             smbus_oe_n,
    output logic             clocks_stable,
    output logic             link_settled
);
    typedef struct packed {
        logic [11:0] cpu_ctrl;
        logic [3:0]  io_ctrl;
        logic [1:0]  disp_ctrl;
        logic [4:0]  link_ctrl;
        logic        pci_clk_d;
        logic        pci_halt_s;
        logic [2:0]  cpu_resume;
        logic        cpu_halt_s;
        logic [16:0] stable_cnt;
        logic [16:0] spread_cnt;
        logic        link_oe_n;
        logic        smbus_oe_n;
        logic        stable;
        logic        settled;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } cosc_st_t;

    cosc_st_t st_reg;
    cosc_st_t st_next;

    cosc_pkg::cosc_mode_t cpu_want [3];
    cosc_pkg::cosc_mode_t cpu_have [3];
    cosc_pkg::cosc_mode_t io_want;
    cosc_pkg::cosc_mode_t io_have;
    cosc_pkg::cosc_mode_t disp_want;
    cosc_pkg::cosc_mode_t disp_have;

    logic access;
    logic pci_edge;
    assign access   = psel && penable && st_reg.pready;
    assign pci_edge = free_pci_clock && !st_reg.pci_clk_d;

    // per-output mode selection, one boundary before the follower
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_cpu
            logic [3:0] c;
            assign c = st_reg.cpu_ctrl[g*cosc_pkg::F_WIDTH +: cosc_pkg::F_WIDTH];
            always_comb begin
                if (!c[cosc_pkg::F_OE]) begin
                    cpu_want[g] = cosc_pkg::COSC_TRI;
                end else if (power_down_pin) begin
                    cpu_want[g] = c[cosc_pkg::F_PD_TRI] ? cosc_pkg::COSC_TRI
                                                        : cosc_pkg::COSC_IREF2;
                end else if (st_reg.cpu_halt_s && !c[cosc_pkg::F_FREE]) begin
                    cpu_want[g] = c[cosc_pkg::F_HALT_TRI] ? cosc_pkg::COSC_TRI
                                                          : cosc_pkg::COSC_IREF6;
                end else begin
                    cpu_want[g] = cosc_pkg::COSC_RUN;
                end
            end
            cosc_delay u_cpu (
                .mclk  (mclk),
                .rst_n (rst_n),
                .want  (cpu_want[g]),
                .mode  (cpu_have[g])
            );
        end
    endgenerate

    always_comb begin
        if (!st_reg.io_ctrl[cosc_pkg::F_OE]) begin
            io_want = cosc_pkg::COSC_TRI;
        end else if (power_down_pin) begin
            io_want = st_reg.io_ctrl[cosc_pkg::F_PD_TRI] ? cosc_pkg::COSC_TRI
                                                         : cosc_pkg::COSC_IREF2;
        end else if (st_reg.pci_halt_s && !st_reg.io_ctrl[cosc_pkg::F_FREE]) begin
            io_want = st_reg.io_ctrl[cosc_pkg::F_HALT_TRI] ? cosc_pkg::COSC_TRI
                                                           : cosc_pkg::COSC_IREF6;
        end else begin
            io_want = cosc_pkg::COSC_RUN;
        end
        if (!st_reg.disp_ctrl[cosc_pkg::F_OE]) begin
            disp_want = cosc_pkg::COSC_TRI;
        end else if (power_down_pin) begin
            disp_want = st_reg.disp_ctrl[cosc_pkg::F_PD_TRI] ? cosc_pkg::COSC_TRI
                                                             : cosc_pkg::COSC_IREF2;
        end else begin
            disp_want = cosc_pkg::COSC_RUN;
        end
    end

    cosc_delay u_io (
        .mclk  (mclk),
        .rst_n (rst_n),
        .want  (io_want),
        .mode  (io_have)
    );

    cosc_delay u_disp (
        .mclk  (mclk),
        .rst_n (rst_n),
        .want  (disp_want),
        .mode  (disp_have)
    );

    always_comb begin
        st_next = st_reg;
        st_next.pci_clk_d = free_pci_clock;
        // sample pci halt on free clock edge
        if (pci_edge) begin
            st_next.pci_halt_s = !pci_halt_n;
        end
        // stop at once, resume after a short count
        if (!cpu_halt_n) begin
            st_next.cpu_halt_s = 1'b1;
            st_next.cpu_resume = 3'h0;
        end else if (st_reg.cpu_halt_s) begin
            st_next.cpu_resume = st_reg.cpu_resume + 3'h1;
            if (st_reg.cpu_resume == 3'(cosc_pkg::CPU_RESUME_MIN - 1)) begin
                st_next.cpu_halt_s = 1'b0;
            end
        end
        st_next.smbus_oe_n = link_power_down_pin;
        st_next.link_oe_n  = link_power_down_pin || !st_reg.link_ctrl[cosc_pkg::F_OE];
        // stabilization count after link powerdown release
        if (link_power_down_pin) begin
            st_next.stable_cnt = 17'h0;
            st_next.stable     = 1'b0;
        end else if (st_reg.stable_cnt == 17'(cosc_pkg::STABLE_CYC - 1)) begin
            st_next.stable = 1'b1;
        end else begin
            st_next.stable_cnt = st_reg.stable_cnt + 17'h1;
        end
        if (st_reg.spread_cnt == 17'(cosc_pkg::SPREAD_CYC - 1)) begin
            st_next.settled = 1'b1;
        end else begin
            st_next.spread_cnt = st_reg.spread_cnt + 17'h1;
        end
        // apb: one wait state, pready high in access phase
        st_next.pready  = psel && !st_reg.pready && penable;
        st_next.pslverr = 1'b0;
        if (psel && penable && !st_reg.pready) begin
            st_next.prdata = 32'h0;
            case (paddr)
                cosc_pkg::CPU_CTRL_OFS:  st_next.prdata = {20'h0, st_reg.cpu_ctrl};
                cosc_pkg::IO_CTRL_OFS:   st_next.prdata = {28'h0, st_reg.io_ctrl};
                cosc_pkg::DISP_CTRL_OFS: st_next.prdata = {30'h0, st_reg.disp_ctrl};
                cosc_pkg::LINK_CTRL_OFS: st_next.prdata = {27'h0, st_reg.link_ctrl};
                cosc_pkg::STATUS_OFS:    st_next.prdata = {28'h0, st_reg.settled,
                                                           st_reg.stable,
                                                           st_reg.pci_halt_s,
                                                           st_reg.cpu_halt_s};
                default:                 st_next.pslverr = 1'b1;
            endcase
        end
        if (access && pwrite) begin
            case (paddr)
                cosc_pkg::CPU_CTRL_OFS:  st_next.cpu_ctrl  = pwdata[11:0];
                cosc_pkg::IO_CTRL_OFS:   st_next.io_ctrl   = pwdata[3:0];
                cosc_pkg::DISP_CTRL_OFS: st_next.disp_ctrl = pwdata[1:0];
                cosc_pkg::LINK_CTRL_OFS: begin
                    st_next.link_ctrl = pwdata[4:0];
                    if (pwdata[4:1] != st_reg.link_ctrl[4:1]) begin
                        st_next.spread_cnt = 17'h0;
                        st_next.settled    = 1'b0;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= '{cpu_ctrl: cosc_pkg::CPU_CTRL_RST, io_ctrl: cosc_pkg::IO_CTRL_RST,
                        disp_ctrl: cosc_pkg::DISP_CTRL_RST, link_ctrl: cosc_pkg::LINK_CTRL_RST,
                        link_oe_n: 1'b1, smbus_oe_n: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs are registered; powerdown parks via the follower, never mid-cycle
    assign cpu_mode                 = {cpu_have[2], cpu_have[1], cpu_have[0]};
    assign io_reference_clock_mode  = io_have;
    assign display_96mhz_clock_mode = disp_have;
    assign link_oe_n                = st_reg.link_oe_n;
    assign smbus_oe_n               = st_reg.smbus_oe_n;
    assign clocks_stable            = st_reg.stable;
    assign link_settled             = st_reg.settled;
    assign prdata                   = st_reg.prdata;
    assign pready                   = st_reg.pready;
    assign pslverr                  = st_reg.pslverr;

    a_pd_tri_io: assert property (@(posedge mclk) disable iff (!rst_n)
        power_down_pin && st_reg.io_ctrl[0] && st_reg.io_ctrl[1]
        |=> io_reference_clock_mode == cosc_pkg::COSC_TRI)
        else $error("io not tristated in powerdown");
    a_oe_off_cpu0: assert property (@(posedge mclk) disable iff (!rst_n)
        !st_reg.cpu_ctrl[0] |=> cpu_mode[1:0] == cosc_pkg::COSC_TRI)
        else $error("disabled cpu output not tristated");
    a_link_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
        link_power_down_pin |=> link_oe_n && smbus_oe_n)
        else $error("link pins driven in powerdown");
    a_oe_within: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(disp_want) ##1 disp_want == $past(disp_want)
        |-> display_96mhz_clock_mode == $past(disp_want))
        else $error("display mode slow");
    a_pci_sample: assert property (@(posedge mclk) disable iff (!rst_n)
        !pci_edge |=> st_reg.pci_halt_s == $past(st_reg.pci_halt_s))
        else $error("pci halt changed without edge");
    a_disp_pd_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        power_down_pin && st_reg.disp_ctrl == 2'h1
        |=> display_96mhz_clock_mode == cosc_pkg::COSC_IREF2)
        else $error("display not at iref2");
    a_cpu_halt_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        !cpu_halt_n && !power_down_pin && st_reg.cpu_ctrl[3:0] == 4'h1
        ##1 !power_down_pin && st_reg.cpu_ctrl[3:0] == 4'h1
        |=> cpu_mode[1:0] == cosc_pkg::COSC_IREF6)
        else $error("stoppable cpu not parked");
    a_cpu_resume: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(cpu_halt_n) |-> ##[1:6] !st_reg.cpu_halt_s)
        else $error("cpu halt not released");
    a_io_halt_tri: assert property (@(posedge mclk) disable iff (!rst_n)
        !power_down_pin && st_reg.pci_halt_s && st_reg.io_ctrl == 4'h5
        |=> io_reference_clock_mode == cosc_pkg::COSC_TRI)
        else $error("io halt tristate missing");
    a_pd_tri_cpu1: assert property (@(posedge mclk) disable iff (!rst_n)
        power_down_pin && st_reg.cpu_ctrl[4] && st_reg.cpu_ctrl[5]
        |=> cpu_mode[3:2] == cosc_pkg::COSC_TRI)
        else $error("cpu1 not tristated in powerdown");
    a_pd_drive_io: assert property (@(posedge mclk) disable iff (!rst_n)
        power_down_pin && st_reg.io_ctrl[1:0] == 2'h1
        |=> io_reference_clock_mode == cosc_pkg::COSC_IREF2)
        else $error("io not at iref2 in powerdown");
    a_oe_off_io: assert property (@(posedge mclk) disable iff (!rst_n)
        !st_reg.io_ctrl[0] |=> io_reference_clock_mode == cosc_pkg::COSC_TRI)
        else $error("disabled io output not tristated");
    a_free_cpu_runs: assert property (@(posedge mclk) disable iff (!rst_n)
        !power_down_pin && st_reg.cpu_ctrl[3:0] == 4'h9
        |=> cpu_mode[1:0] == cosc_pkg::COSC_RUN)
        else $error("free running cpu output stopped");
    a_disp_ignores_halt: assert property (@(posedge mclk) disable iff (!rst_n)
        !power_down_pin && st_reg.disp_ctrl[0]
        |=> display_96mhz_clock_mode == cosc_pkg::COSC_RUN)
        else $error("display clock not running");
    a_link_driven: assert property (@(posedge mclk) disable iff (!rst_n)
        !link_power_down_pin && st_reg.link_ctrl[0] |=> !link_oe_n)
        else $error("enabled link not driven");
    a_stable_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        link_power_down_pin |=> !clocks_stable)
        else $error("stable flag kept in link powerdown");
    a_spread_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        access && pwrite && paddr == cosc_pkg::LINK_CTRL_OFS
        && pwdata[4:1] != st_reg.link_ctrl[4:1]
        |=> !link_settled)
        else $error("spread change did not restart settling");
    c_pd: cover property (@(posedge mclk) power_down_pin ##2 cpu_mode[1:0] == 2'b10);
    c_halt: cover property (@(posedge mclk) !cpu_halt_n ##2 cpu_mode[1:0] == 2'b01);
    c_pci: cover property (@(posedge mclk) pci_edge && !pci_halt_n);
    c_wr: cover property (@(posedge mclk) access && pwrite);
    c_link_pd: cover property (@(posedge mclk) link_power_down_pin ##1 link_oe_n && smbus_oe_n);
endmodule // cosc_ctrl
`default_nettype wire

// ===== cosc_pm_model.sv
`timescale 1ns/1ns
`default_nettype none
// power-management side: drives the halt and powerdown pins as the bench commands
module cosc_pm_model (
    input  wire logic mclk,
    input  wire logic pd_req,
    input  wire logic cpu_halt_req,
    input  wire logic pci_halt_req,
    input  wire logic link_pd_req,
    output logic      power_down_pin,
    output logic      cpu_halt_n,
    output logic      pci_halt_n,
    output logic      free_pci_clock,
    output logic      link_power_down_pin
);
    initial begin
        power_down_pin = 1'b0;
        cpu_halt_n = 1'b1;
        pci_halt_n = 1'b1;
        free_pci_clock = 1'b0;
        link_power_down_pin = 1'b0;
    end
    // free pci clock
    // never stopped, so a pci halt is always sampled; its edges never meet a rising mclk edge
    always #16 free_pci_clock = ~free_pci_clock;
    // pin levels
    // powerdown active high, both halts active low
    always @(posedge mclk) begin
        power_down_pin <= pd_req;
        cpu_halt_n <= ~cpu_halt_req;
        pci_halt_n <= ~pci_halt_req;
        link_power_down_pin <= link_pd_req;
    end
endmodule // cosc_pm_model
`default_nettype wire

// ===== clock_output_state_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module clock_output_state_control_tb;
    logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic        pready, pslverr, er, pd, ch_n, ph_n, fpc, lpd;
    logic        pd_r = 0, ch_r = 0, ph_r = 0, lpd_r = 0;
    logic [5:0]  cpu_mode;
    logic [1:0]  io_mode, disp_mode;
    logic        link_oe_n, smbus_oe_n, clocks_stable, link_settled;
    int          n_mismatch = 0, checked = 0, seed = 44500, cyc = 0;
    int          t_rel = 0, t_w2 = 0, t_st = 0, t_se = 0, n;
    logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h111, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0};

    always #20 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    always @(negedge mclk) begin
        if (clocks_stable === 1'b1 && t_st == 0) t_st = cyc;
        if (link_settled === 1'b1 && t_w2 != 0 && t_se == 0 && cyc > t_w2) t_se = cyc;
    end

    cosc_ctrl i_cosc_ctrl (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_down_pin(pd), .cpu_halt_n(ch_n),
        .pci_halt_n(ph_n), .free_pci_clock(fpc), .link_power_down_pin(lpd),
        .cpu_mode(cpu_mode), .io_reference_clock_mode(io_mode),
        .display_96mhz_clock_mode(disp_mode), .link_oe_n(link_oe_n),
        .smbus_oe_n(smbus_oe_n), .clocks_stable(clocks_stable), .link_settled(link_settled));
    cosc_pm_model i_cosc_pm_model (.mclk(mclk), .pd_req(pd_r), .cpu_halt_req(ch_r),
        .pci_halt_req(ph_r), .link_pd_req(lpd_r), .power_down_pin(pd), .cpu_halt_n(ch_n),
        .pci_halt_n(ph_n), .free_pci_clock(fpc), .link_power_down_pin(lpd));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the watchdog bounds a slave that never answers
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [1:0] exp1(input logic [3:0] c, input logic p, input logic h);
        if (!c[0]) return cosc_pkg::COSC_TRI;
        if (p) return c[1] ? cosc_pkg::COSC_TRI : cosc_pkg::COSC_IREF2;
        if (h && !c[3]) return c[2] ? cosc_pkg::COSC_TRI : cosc_pkg::COSC_IREF6;
        return cosc_pkg::COSC_RUN;
    endfunction

    // waits out the whole output enable delay, so a passing transient cannot hide a late error
    task automatic wmode(input logic [9:0] e);
        repeat (cosc_pkg::OE_DELAY_CYC) @(negedge mclk);
        chk("modes", {22'h0, e}, {22'h0, cpu_mode, io_mode, disp_mode});
    endtask

    task automatic tally_and_finish();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(40 * 100000);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("reset modes", 32'h3ff, {22'h0, cpu_mode, io_mode, disp_mode});
        chk("reset link oe", 32'h1, {31'h0, link_oe_n});
        @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        t_rel = cyc;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            chk("read", rv[i], rd);
            chk("slverr", {31'h0, i == 5}, {31'h0, er});
        end
        apb(1'b1, 8'h0c, 32'h3);
        repeat (1000) @(posedge mclk);
        apb(1'b1, 8'h0c, 32'h5);
        t_w2 = cyc;
        @(negedge mclk);
        chk("settled low", 32'h0, {31'h0, link_settled});
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            if (i == 0) r = 32'h7;
            apb(1'b1, 8'h00, {20'h0, r[31:20]});
            apb(1'b1, 8'h04, {28'h0, r[19:16]});
            apb(1'b1, 8'h08, {30'h0, r[15:14]});
            apb(1'b0, 8'h00, 32'h0);
            chk("cpu ctrl", {20'h0, r[31:20]}, rd);
            @(posedge mclk);
            {pd_r, ch_r, ph_r} <= r[2:0];
            @(negedge mclk);
            wmode({exp1(r[31:28], r[2], r[1]), exp1(r[27:24], r[2], r[1]),
                   exp1(r[23:20], r[2], r[1]), exp1(r[19:16], r[2], r[0]),
                   exp1({2'b00, r[15:14]}, r[2], 1'b0)});
        end
        apb(1'b1, 8'h0c, 32'h4);
        repeat (cosc_pkg::OE_DELAY_CYC) @(negedge mclk);
        chk("link disabled", 32'h1, {31'h0, link_oe_n});
        apb(1'b1, 8'h0c, 32'h5);
        repeat (cosc_pkg::OE_DELAY_CYC) @(negedge mclk);
        chk("link enabled", 32'h0, {31'h0, link_oe_n});
        n = 0;
        while ((t_st == 0 || t_se == 0) && n < 80000) begin
            @(negedge mclk);
            n++;
        end
        chk("stable time", 32'h1, {31'h0, t_st != 0 && t_st - t_rel <= cosc_pkg::STABLE_CYC + 4});
        chk("settle time", 32'h1, {31'h0, t_se - t_w2 >= cosc_pkg::SPREAD_CYC - 4
            && t_se - t_w2 <= cosc_pkg::SPREAD_CYC + 4});
        @(posedge mclk);
        lpd_r <= 1'b1;
        repeat (cosc_pkg::OE_DELAY_CYC) @(negedge mclk);
        chk("link pd oe", 32'h3, {30'h0, link_oe_n, smbus_oe_n});
        chk("stable cleared", 32'h0, {31'h0, clocks_stable});
        @(posedge mclk);
        lpd_r <= 1'b0;
        repeat (cosc_pkg::OE_DELAY_CYC) @(negedge mclk);
        chk("link release oe", 32'h0, {30'h0, link_oe_n, smbus_oe_n});
        tally_and_finish();
    end
endmodule // clock_output_state_control_tb
`default_nettype wire
